// ==== logic/dph_decoder.sv ====
// Purpose: receive-side packet decoder: checksum, type decode, pixel unpack
// Assumes: link clock, burst flag and byte pins sampled by sys_clk (10 MHz)
// Notes:   long write bytes and pixels stream live; pkt_good says keep them
`timescale 1ns/1ps
`include "dph_map.svh"
module dph_decoder (
    input  wire logic          sys_clk,               // 10 MHz system clock
    input  wire logic          rst,                   // Synchronous, active high
    input  wire logic          link_clk,              // Link byte clock pin
    input  wire logic          link_hs,               // High-speed burst active pin
    input  wire logic [7:0]    link_byte,             // Link byte pins
    input  wire logic          err_clear,             // Clears sticky errors
    input  wire logic          pix_ready,             // Frame memory takes pixel
    output dph_pkg::dph_evt_type timing_evt,          // Sync event pulses
    output dph_pkg::dph_cmd_type cmd,                 // Short command pulses
    output dph_pkg::dph_lw_type  lw,                  // Long command write bytes
    output logic               pkt_done,              // Long packet finished
    output logic               pkt_good,              // Finished packet is clean
    output logic               reduced_colour_select, // Low colour mode level
    output logic               display_on,            // Display enabled level
    output logic [15:0]        max_return_size,       // Max reply payload
    output dph_pkg::dph_err_type err_flags,           // Sticky error flags
    output logic               pix_valid,             // Pixel buffer head valid
    output dph_pkg::dph_pix_type pix_data             // Pixel buffer head
);
    import dph_pkg::*;

    dph_regs_type r;    // Registered state
    dph_regs_type n;    // Next state

    // Payload types whose length comes from the word count
    function automatic logic is_long(input logic [5:0] dt);
        return (dt == `DPH_DT_NULL) || (dt == `DPH_DT_BLANK) || (dt == `DPH_DT_DCS_LONG) ||
               (dt == `DPH_DT_PIX16) || (dt == `DPH_DT_PIX18) ||
               (dt == `DPH_DT_PIX18L) || (dt == `DPH_DT_PIX24);
    endfunction

    // Short types that mean something here
    function automatic logic is_short_known(input logic [5:0] dt);
        case (dt)
            `DPH_DT_VS_START, `DPH_DT_VS_END, `DPH_DT_HS_START, `DPH_DT_HS_END,
            `DPH_DT_EOT, `DPH_DT_CM_ON, `DPH_DT_CM_OFF, `DPH_DT_SHUTDOWN,
            `DPH_DT_TURN_ON, `DPH_DT_GEN_WR0, `DPH_DT_GEN_WR1, `DPH_DT_GEN_WR2,
            `DPH_DT_GEN_RD0, `DPH_DT_GEN_RD1, `DPH_DT_GEN_RD2, `DPH_DT_DCS_WR0,
            `DPH_DT_DCS_WR1, `DPH_DT_DCS_RD, `DPH_DT_MAX_RET: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // One payload byte through the checksum, top bit first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        logic        fb;
        x = c;
        for (int i = 7; i >= 0; i--) begin
            fb = x[15] ^ d[i];
            x  = {x[14:0], 1'b0} ^ (fb ? `DPH_CRC_POLY : 16'h0000);
        end
        return x;
    endfunction

    // Next-state logic: sampling, parsing, unpacking and pixel buffer
    always_comb begin
        logic        edge_seen;   // Link clock rose
        logic [7:0]  b;           // Byte taken on that edge
        logic        push;        // Pixel produced this cycle
        dph_pix_type pin;         // That pixel
        logic [25:0] accw;        // Widened tight-pack accumulator
        logic [4:0]  acntw;       // Bits held after this byte
        logic        pop;         // Head leaves the buffer
        edge_seen = 1'b0;
        b         = 8'h00;
        push      = 1'b0;
        pin       = '0;
        accw      = '0;
        acntw     = '0;
        pop       = 1'b0;
        n = r;
        // Pulses last one cycle
        n.evt = '0;
        n.cmd = '0;
        n.lw = '0;
        n.pkt_done = 1'b0;
        n.pkt_good = 1'b0;
        n.sp_done = 1'b0;
        // Clear first so that a set in the same cycle wins
        if (err_clear) begin
            n.err = '0;
        end
        // Two flops on every pin before use
        n.lk_s1 = link_clk;
        n.lk_s2 = r.lk_s1;
        n.lk_s3 = r.lk_s2;
        n.hs_s1 = link_hs;
        n.hs_s2 = r.hs_s1;
        n.by_s1 = link_byte;
        n.by_s2 = r.by_s1;
        edge_seen = r.lk_s2 & ~r.lk_s3;
        b = r.by_s2;
        // Parser keeps running whatever the display state is
        if (!r.hs_s2) begin
            // Outside a burst the next byte is always a header
            n.phase = DPH_HDR;
            n.hidx  = '0;
        end else if (edge_seen) begin
            case (r.phase)
                DPH_HDR: begin
                    n.hidx = r.hidx + 2'h1;
                    case (r.hidx)
                        2'h0: n.dt = b[5:0];
                        2'h1: n.d0 = b;
                        2'h2: n.d1 = b;
                        default: begin
                            // Header complete; ECC byte not checked here
                            if (is_long(r.dt)) begin
                                n.rem   = {r.d1, r.d0};
                                n.crc   = `DPH_CRC_INIT;
                                n.acc   = '0;
                                n.acnt  = '0;
                                n.pidx  = '0;
                                n.fidx  = 1'b0;
                                n.known = 1'b1;
                                n.phase = ({r.d1, r.d0} == 16'h0000) ? DPH_FTR : DPH_PAY;
                            end else begin
                                n.sp_done = 1'b1;
                                n.cmd.p0  = r.d0;
                                n.cmd.p1  = r.d1;
                                case (r.dt)
                                    `DPH_DT_VS_START: begin
                                        n.evt.vs_start = 1'b1;
                                        n.evt.hs_start = 1'b1;
                                    end
                                    `DPH_DT_VS_END: begin
                                        n.evt.vs_end   = 1'b1;
                                        n.evt.hs_start = 1'b1;
                                    end
                                    `DPH_DT_HS_START: n.evt.hs_start = 1'b1;
                                    `DPH_DT_HS_END:   n.evt.hs_end = 1'b1;
                                    `DPH_DT_EOT:      n.evt.eot = 1'b1;
                                    `DPH_DT_CM_ON:    n.colour_red = 1'b1;
                                    `DPH_DT_CM_OFF:   n.colour_red = 1'b0;
                                    `DPH_DT_SHUTDOWN: n.disp_on = 1'b0;
                                    `DPH_DT_TURN_ON:  n.disp_on = 1'b1;
                                    `DPH_DT_GEN_WR0, `DPH_DT_GEN_WR1, `DPH_DT_GEN_WR2: begin
                                        n.cmd.gen_wr = 1'b1;
                                        n.cmd.nparam = (r.dt == `DPH_DT_GEN_WR0) ? `DPH_NPARAM_0 :
                                                       (r.dt == `DPH_DT_GEN_WR1) ? `DPH_NPARAM_1 :
                                                       `DPH_NPARAM_2;
                                    end
                                    `DPH_DT_GEN_RD0, `DPH_DT_GEN_RD1, `DPH_DT_GEN_RD2: begin
                                        n.cmd.gen_rd = 1'b1;
                                        n.cmd.nparam = (r.dt == `DPH_DT_GEN_RD0) ? `DPH_NPARAM_0 :
                                                       (r.dt == `DPH_DT_GEN_RD1) ? `DPH_NPARAM_1 :
                                                       `DPH_NPARAM_2;
                                    end
                                    `DPH_DT_DCS_WR0, `DPH_DT_DCS_WR1: begin
                                        // Parameter byte passed as sent, also when unused
                                        n.cmd.dcs_wr = 1'b1;
                                        n.cmd.nparam = (r.dt == `DPH_DT_DCS_WR0) ?
                                                       `DPH_NPARAM_0 : `DPH_NPARAM_1;
                                    end
                                    `DPH_DT_DCS_RD:  n.cmd.dcs_rd = 1'b1;
                                    `DPH_DT_MAX_RET: n.maxret = {r.d1, r.d0};
                                    default: n.err.dtype = 1'b1;
                                endcase
                            end
                        end
                    endcase
                end
                DPH_PAY: begin
                    n.crc = crc_byte(r.crc, b);
                    n.rem = r.rem - 16'h0001;
                    if (r.rem == 16'h0001) begin
                        n.phase = DPH_FTR;
                    end
                    case (r.dt)
                        `DPH_DT_DCS_LONG: begin
                            // Command byte first, then parameter or table bytes
                            n.lw.valid = 1'b1;
                            n.lw.first = (r.rem == {r.d1, r.d0});
                            n.lw.data  = b;
                        end
                        `DPH_DT_PIX16: begin
                            n.pidx = r.pidx ^ 2'h1;
                            n.pb0  = b;
                            if (r.pidx[0]) begin
                                // Narrow red and blue padded below the MSBs
                                push = 1'b1;
                                pin  = '{r: {r.pb0[4:0], 1'b0},
                                         g: {b[2:0], r.pb0[7:5]},
                                         b: {b[7:3], 1'b0}};
                            end
                        end
                        `DPH_DT_PIX18: begin
                            accw  = r.acc | (26'({18'h0, b}) << r.acnt);
                            acntw = 5'(r.acnt + `DPH_BYTE_BITS);
                            if (acntw >= `DPH_PIX_BITS) begin
                                push = 1'b1;
                                pin  = '{r: accw[5:0], g: accw[11:6], b: accw[17:12]};
                                accw = accw >> `DPH_PIX_BITS;
                                acntw = 5'(acntw - `DPH_PIX_BITS);
                            end
                            n.acc  = accw;
                            n.acnt = acntw;
                        end
                        `DPH_DT_PIX18L, `DPH_DT_PIX24: begin
                            // Both keep the top six bits of each byte
                            n.pidx = (r.pidx == 2'h2) ? 2'h0 : 2'(r.pidx + 2'h1);
                            if (r.pidx == 2'h0) begin
                                n.pb0 = b;
                            end else if (r.pidx == 2'h1) begin
                                n.pb1 = b;
                            end else begin
                                push = 1'b1;
                                pin  = '{r: r.pb0[7:2], g: r.pb1[7:2], b: b[7:2]};
                            end
                        end
                        // Null and blanking payloads are only counted
                        `DPH_DT_NULL:  n.known = 1'b1;
                        `DPH_DT_BLANK: n.known = 1'b1;
                        default: n.known = 1'b1;
                    endcase
                end
                DPH_FTR: begin
                    n.fidx = 1'b1;
                    if (!r.fidx) begin
                        n.flo = b;
                    end else begin
                        n.phase    = DPH_HDR;
                        n.hidx     = '0;
                        n.pkt_done = 1'b1;
                        // Footer arrives low byte first
                        n.pkt_good = (r.crc == {b, r.flo});
                        if (r.crc != {b, r.flo}) begin
                            n.err.crc = 1'b1;
                        end else if (r.dt == `DPH_DT_BLANK) begin
                            n.evt.blank = 1'b1;
                        end
                    end
                end
                default: begin
                    n.phase = DPH_HDR;
                    n.hidx  = '0;
                end
            endcase
        end
        // Pixel buffer: head register plus one skid entry
        pop = r.ov_v & pix_ready;
        // A pop in the same cycle frees the skid entry, so nothing is lost then
        if (push && r.sk_v && !pop) begin
            n.err.overrun = 1'b1; // Both entries full, pixel lost
        end
        if (!r.ov_v || pop) begin
            if (r.sk_v) begin
                n.ov   = r.sk;
                n.ov_v = 1'b1;
                n.sk   = pin;
                n.sk_v = push;
            end else begin
                n.ov   = pin;
                n.ov_v = push;
            end
        end else if (push && !r.sk_v) begin
            n.sk   = pin;
            n.sk_v = 1'b1;
        end
    end

    // Register the whole state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r        <= '0;
            r.phase  <= DPH_HDR;
            r.crc    <= `DPH_CRC_INIT;
            r.disp_on <= 1'b1;
            r.maxret <= `DPH_MAXRET_DEF;
        end else begin
            r <= n;
        end
    end

    // Outputs come straight from the state register
    assign timing_evt            = r.evt;
    assign cmd                   = r.cmd;
    assign lw                    = r.lw;
    assign pkt_done              = r.pkt_done;
    assign pkt_good              = r.pkt_good;
    assign reduced_colour_select = r.colour_red;
    assign display_on            = r.disp_on;
    assign max_return_size       = r.maxret;
    assign err_flags             = r.err;
    assign pix_valid             = r.ov_v;
    assign pix_data              = r.ov;

    property p_max_rst;
        @(posedge sys_clk) rst |=> (max_return_size == `DPH_MAXRET_DEF);
    endproperty
    a_max_rst: assert property (p_max_rst) else $error("max reply size not one after reset");

    property p_vs_hs;
        @(posedge sys_clk) disable iff (rst)
        (timing_evt.vs_start || timing_evt.vs_end) |-> timing_evt.hs_start;
    endproperty
    a_vs_hs: assert property (p_vs_hs) else $error("v sync without implied h sync");

    property p_crc_bad;
        @(posedge sys_clk) disable iff (rst)
        (pkt_done && !pkt_good) |-> err_flags.crc ##1 (err_flags.crc || $past(err_clear));
    endproperty
    a_crc_bad: assert property (p_crc_bad) else $error("bad checksum not flagged");

    property p_shutdown;
        @(posedge sys_clk) disable iff (rst)
        (r.sp_done && r.dt == `DPH_DT_SHUTDOWN) |-> !display_on;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("display left on after shutdown");

    property p_colour;
        @(posedge sys_clk) disable iff (rst)
        (r.sp_done && r.dt == `DPH_DT_CM_ON) |-> reduced_colour_select;
    endproperty
    a_colour: assert property (p_colour) else $error("reduced colour not selected");

    property p_maxret;
        @(posedge sys_clk) disable iff (rst)
        (r.sp_done && r.dt == `DPH_DT_MAX_RET) |-> (max_return_size == {r.d1, r.d0});
    endproperty
    a_maxret: assert property (p_maxret) else $error("max reply size not taken");

    property p_null;
        @(posedge sys_clk) disable iff (rst)
        (r.phase == DPH_PAY && r.dt == `DPH_DT_NULL) |=> !lw.valid;
    endproperty
    a_null: assert property (p_null) else $error("null payload was forwarded");

    property p_unknown;
        @(posedge sys_clk) disable iff (rst)
        (r.sp_done && !is_short_known(r.dt)) |->
            err_flags.dtype ##1 (err_flags.dtype || $past(err_clear));
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown type not flagged");

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        (pix_valid && !pix_ready) |=> (pix_valid && $stable(pix_data));
    endproperty
    a_hold: assert property (p_hold) else $error("stalled pixel changed");
endmodule // dph_decoder

// ==== logic/dph_map.svh ====
// Purpose: constants for the link packet decoder (type codes, checksum, counts)
// Assumes: included by its bare name from the decoder
// Notes:   definitions only
`ifndef DPH_MAP_SVH
`define DPH_MAP_SVH
`define DPH_DT_VS_START   6'h01
`define DPH_DT_VS_END     6'h11
`define DPH_DT_HS_START   6'h21
`define DPH_DT_HS_END     6'h31
`define DPH_DT_EOT        6'h08
`define DPH_DT_CM_ON      6'h02
`define DPH_DT_CM_OFF     6'h12
`define DPH_DT_SHUTDOWN   6'h22
`define DPH_DT_TURN_ON    6'h32
`define DPH_DT_GEN_WR0    6'h03
`define DPH_DT_GEN_WR1    6'h13
`define DPH_DT_GEN_WR2    6'h23
`define DPH_DT_GEN_RD0    6'h04
`define DPH_DT_GEN_RD1    6'h14
`define DPH_DT_GEN_RD2    6'h24
`define DPH_DT_DCS_WR0    6'h05
`define DPH_DT_DCS_WR1    6'h15
`define DPH_DT_DCS_RD     6'h06
`define DPH_DT_MAX_RET    6'h37
`define DPH_DT_NULL       6'h09
`define DPH_DT_BLANK      6'h19
`define DPH_DT_DCS_LONG   6'h39
`define DPH_DT_PIX16      6'h0E
`define DPH_DT_PIX18      6'h1E
`define DPH_DT_PIX18L     6'h2E
`define DPH_DT_PIX24      6'h3E
`define DPH_CRC_INIT      16'hFFFF
`define DPH_CRC_POLY      16'h1021
`define DPH_MAXRET_DEF    16'h0001
`define DPH_HDR_LAST      2'h3
`define DPH_BYTE_BITS     5'h08
`define DPH_PIX_BITS      5'h12
`define DPH_NPARAM_0      2'h0
`define DPH_NPARAM_1      2'h1
`define DPH_NPARAM_2      2'h2
`endif

// ==== logic/dph_pkg.sv ====
// Purpose: carrier and state types for the link packet decoder
// Assumes: constants come from dph_map.svh
// Notes:   the decoder keeps its whole state in dph_regs_type
package dph_pkg;
    typedef enum logic [1:0] {DPH_HDR, DPH_PAY, DPH_FTR} dph_phase_type;
    typedef struct packed {
        logic vs_start; logic vs_end; logic hs_start; logic hs_end;
        logic eot; logic blank;
    } dph_evt_type;
    typedef struct packed {
        logic gen_wr; logic gen_rd; logic dcs_wr; logic dcs_rd;
        logic [1:0] nparam; logic [7:0] p0; logic [7:0] p1;
    } dph_cmd_type;
    typedef struct packed { logic valid; logic first; logic [7:0] data; } dph_lw_type;
    typedef struct packed { logic [5:0] r; logic [5:0] g; logic [5:0] b; } dph_pix_type;
    typedef struct packed { logic crc; logic dtype; logic overrun; } dph_err_type;
    typedef struct packed {
        logic lk_s1; logic lk_s2; logic lk_s3; logic hs_s1; logic hs_s2;
        logic [7:0] by_s1; logic [7:0] by_s2;
        dph_phase_type phase;
        logic [1:0] hidx; logic [5:0] dt; logic [7:0] d0; logic [7:0] d1;
        logic [15:0] rem; logic fidx; logic [7:0] flo; logic [15:0] crc;
        logic [25:0] acc; logic [4:0] acnt; logic [1:0] pidx;
        logic [7:0] pb0; logic [7:0] pb1; logic known;
        dph_evt_type evt; dph_cmd_type cmd; dph_lw_type lw;
        logic pkt_done; logic pkt_good; logic sp_done;
        logic colour_red; logic disp_on; logic [15:0] maxret;
        dph_err_type err;
        logic ov_v; dph_pix_type ov; logic sk_v; dph_pix_type sk;
    } dph_regs_type;
endpackage

// ==== tb/dph_decoder_tb.sv ====
// Purpose: self-checking bench for the link packet decoder
// Assumes: host model drives the link; inputs change at falling edges
// Notes:   a monitor gathers pulses; each scenario judges them
`timescale 1ns/1ps
module dph_decoder_tb;
    import dph_pkg::*;
    logic        sys_clk, rst, err_clear, pix_ready, link_clk, link_hs;
    logic        pkt_done, pkt_good, rcs, don, pix_valid;
    logic [7:0]  link_byte;
    logic [15:0] mrs;
    logic [1:0]  dn;          // Last long packet end: seen, good
    dph_evt_type ev, ev_acc;  // Event pulses and their sum
    dph_cmd_type cm, cm_last;
    dph_lw_type  lw;
    dph_err_type ef;
    dph_pix_type px;
    logic [31:0] lw_q[$], px_q[$];
    int          n_mismatch = 0, checks = 0, cyc = 0;
    dph_decoder DUT (
        .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .link_hs(link_hs),
        .link_byte(link_byte), .err_clear(err_clear), .pix_ready(pix_ready),
        .timing_evt(ev), .cmd(cm), .lw(lw), .pkt_done(pkt_done), .pkt_good(pkt_good),
        .reduced_colour_select(rcs), .display_on(don), .max_return_size(mrs),
        .err_flags(ef), .pix_valid(pix_valid), .pix_data(px));
    dph_link_host host (.link_clk(link_clk), .link_hs(link_hs), .link_byte(link_byte));
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Monitor and hang guard; a run needs far fewer cycles than this
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        ev_acc <= ev_acc | ev;
        if (cm.gen_wr | cm.gen_rd | cm.dcs_wr | cm.dcs_rd) cm_last <= cm;
        if (lw.valid) lw_q.push_back(32'({lw.first, lw.data}));
        if (pix_valid & pix_ready) px_q.push_back(32'(px));
        if (pkt_done) dn <= {1'h1, pkt_good};
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Clear, send, then wait out the four-edge answer
    task automatic sp(input logic [5:0] dt, input logic [7:0] d0, input logic [7:0] d1);
        {ev_acc, cm_last, dn} = '0;
        host.short_pkt(dt, d0, d1);
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic lp(input logic [5:0] dt, input logic [7:0] pl[$], input logic bad);
        {ev_acc, cm_last, dn} = '0;
        lw_q.delete();
        px_q.delete();
        host.long_pkt(dt, pl, bad);
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic eclr;
        err_clear = 1'h1;
        @(negedge sys_clk) err_clear = 1'h0;
        chk(32'(ef), 32'h0);
    endtask
    // Syncs and end of burst while the display is shut down
    task automatic t_sync;
        logic [5:0] dt[5] = '{6'h01, 6'h11, 6'h21, 6'h31, 6'h08};
        logic [5:0] ex[5] = '{6'h28, 6'h18, 6'h08, 6'h04, 6'h02};
        sp(6'h22, 8'h00, 8'h00);
        chk(32'(don), 32'h0);
        for (int i = 0; i < 5; i++) begin
            sp(dt[i], 8'h00, 8'h00);
            chk(32'(ev_acc), {26'h0, ex[i]});
        end
        sp(6'h32, 8'h00, 8'h00);
        chk(32'(don), 32'h1);
    endtask
    // Colour mode and reply size, checked against reset values first
    task automatic t_modes;
        chk(32'(mrs), 32'h1);
        chk(32'(rcs), 32'h0);
        sp(6'h02, 8'h00, 8'h00);
        chk(32'(rcs), 32'h1);
        sp(6'h12, 8'h00, 8'h00);
        chk(32'(rcs), 32'h0);
        sp(6'h37, 8'h34, 8'h12);
        chk(32'(mrs), 32'h1234);
    endtask
    // Every command code, then a reserved one
    task automatic t_cmds;
        logic [5:0] dt[9] = '{6'h03, 6'h13, 6'h23, 6'h04, 6'h14, 6'h24, 6'h05, 6'h15, 6'h06};
        logic [5:0] ex[9] = '{6'h20, 6'h21, 6'h22, 6'h10, 6'h11, 6'h12, 6'h08, 6'h09, 6'h04};
        for (int i = 0; i < 9; i++) begin
            sp(dt[i], 8'h3C, 8'h00);
            chk(32'(cm_last[21:16]), {26'h0, ex[i]});
            chk(32'(cm_last[15:0]), 32'h3C00);
        end
        sp(6'h10, 8'h3C, 8'h00);
        chk(32'(cm_last[21:16]), 32'h0);
        chk(32'(ef), 32'h2);
        eclr;
    endtask
    // Long writes good and corrupt, null and blanking packets
    task automatic t_long;
        lp(6'h39, '{8'h2C, 8'h11, 8'h22}, 1'h0);
        chk(32'(lw_q.size()), 32'h3);
        chk(lw_q[0], 32'h12C);
        chk(lw_q[2], 32'h022);
        chk(32'(dn), 32'h3);
        lp(6'h39, '{8'h2C, 8'h11}, 1'h1);
        chk(32'(dn), 32'h2);
        chk(32'(ef), 32'h4);
        eclr;
        lp(6'h09, '{8'hFF, 8'h00}, 1'h0);
        chk(32'(lw_q.size() + px_q.size()), 32'h0);
        chk(32'(dn), 32'h3);
        lp(6'h19, '{8'h00, 8'h00, 8'h00}, 1'h0);
        chk(32'(ev_acc), 32'h1);
    endtask
    // Each pixel format; the tight one leaves six bits to drop
    task automatic t_pix;
        lp(6'h1E, '{8'hEF, 8'hCD, 8'hAB}, 1'h0);
        chk(32'(px_q.size()), 32'h1);
        chk(px_q[0], {14'h0, 6'h2F, 6'h37, 6'h3C});
        lp(6'h3E, '{8'hFC, 8'h80, 8'h04}, 1'h0);
        chk(px_q[0], {14'h0, 6'h3F, 6'h20, 6'h01});
        lp(6'h2E, '{8'hFD, 8'h83, 8'h06}, 1'h0);
        chk(px_q[0], {14'h0, 6'h3F, 6'h20, 6'h01});
        lp(6'h0E, '{8'hB3, 8'h6E}, 1'h0);
        chk(px_q[0], {14'h0, 6'h26, 6'h35, 6'h1A});
    endtask
    // Stalled receiver: two pixels kept, the third overruns
    task automatic t_stall;
        pix_ready = 1'h0;
        lp(6'h3E, '{8'hFC, 8'h80, 8'h04, 8'hFC, 8'h80, 8'h04, 8'hFC, 8'h80, 8'h04}, 1'h0);
        chk(32'(ef), 32'h1);
        pix_ready = 1'h1;
        repeat (4) @(negedge sys_clk);
        chk(32'(px_q.size()), 32'h2);
        chk(32'(pix_valid), 32'h0);
    endtask
    initial begin
        {rst, err_clear, pix_ready} = 3'h5;
        {ev_acc, cm_last, dn} = '0;
        repeat (8) @(negedge sys_clk);
        rst = 1'h0;
        t_modes;
        t_sync;
        t_cmds;
        t_long;
        t_pix;
        t_stall;
        give_verdict;
    end
endmodule // dph_decoder_tb

// ==== tb/dph_link_host.sv ====
// Purpose: host model driving the link pins for the decoder bench
// Assumes: link clock 800 ns, byte set 400 ns before its rise, held 300 ns after
// Notes:   clock stands still between packets; released byte pins invert
`timescale 1ns/1ps
module dph_link_host (
    output logic       link_clk,  // Byte clock, idle low
    output logic       link_hs,   // Burst flag
    output logic [7:0] link_byte  // Byte pins
);
    // Burst off at time zero, so nothing is sent before reset ends
    initial {link_clk, link_hs, link_byte} = 10'h0A5;
    // One byte; pins invert after the hold so no stale value lingers
    // Inverting before the clock falls keeps one byte change per time step
    task automatic put(input logic [7:0] b);
        link_hs = 1'h1;
        link_byte = b;
        #400 link_clk = 1'h1;
        #300 link_byte = ~b;
        #100 link_clk = 1'h0;
    endtask
    // Short packet or long header; the ECC byte is left zero
    task automatic short_pkt(input logic [5:0] dt, input logic [7:0] d0, input logic [7:0] d1);
        put({2'h0, dt});
        put(d0);
        put(d1);
        put(8'h00);
    endtask
    // Long packet; bad corrupts the footer on purpose
    task automatic long_pkt(input logic [5:0] dt, input logic [7:0] pl[$], input logic bad);
        logic [15:0] c;
        c = 16'hFFFF;
        short_pkt(dt, 8'(pl.size()), 8'(pl.size() >> 8));
        foreach (pl[i]) begin
            put(pl[i]);
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'h0} ^ ((c[15] ^ pl[i][k]) ? 16'h1021 : 16'h0000);
        end
        put(bad ? ~c[7:0] : c[7:0]);
        put(c[15:8]);
    endtask
endmodule // dph_link_host
